// *** rtl/cocr_regs.sv ***
// channel one configuration register bank with decoded controls
// assumes the serial control port delivers one-cycle strobes on mclk
`timescale 1ns/1ps
`default_nettype none

module cocr_regs (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       regStrobe,
  input  wire logic       regWrite,
  input  wire logic [7:0] regPage,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       boostModeSel,
  output logic [7:0]      regRdData,
  output logic            regAck,
  output logic            chanOneInputKind,
  output logic [1:0]      chanOneSourceSelect,
  output logic            chanOneSourceReserved,
  output logic            chanOneCoupling,
  output logic [1:0]      chanOneImpedance,
  output logic            chanOneImpedanceReserved,
  output logic            chanOneRangeBoostOn,
  output logic            chanOneGainControlOn,
  output logic [5:0]      chanOneAnalogGain,
  output logic            chanOneGainReserved,
  output logic            chanOneVolumeMuted,
  output logic [8:0]      chanOneVolume,
  output logic [4:0]      chanOneGainTrim
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic [7:0] inputCfg;
  logic [7:0] analogGain;
  logic [7:0] digVolume;
  logic [7:0] calibrate;

  wire logic       pageHit;
  wire logic       hitInput;
  wire logic       hitGain;
  wire logic       hitVolume;
  wire logic       hitCal;
  wire logic       anyHit;
  wire logic       doWrite;
  wire logic       doRead;
  wire logic [7:0] readMux;

  assign pageHit   = (regPage == cocr_pkg::PAGE_CONFIG);
  assign hitInput  = pageHit && (regAddr == cocr_pkg::ADDR_INPUT_CFG);
  assign hitGain   = pageHit && (regAddr == cocr_pkg::ADDR_ANALOG_GN);
  assign hitVolume = pageHit && (regAddr == cocr_pkg::ADDR_DIG_VOLUME);
  assign hitCal    = pageHit && (regAddr == cocr_pkg::ADDR_CALIBRATE);
  assign anyHit    = hitInput || hitGain || hitVolume || hitCal;
  assign doWrite   = regStrobe && regWrite;
  assign doRead    = regStrobe && !regWrite && anyHit;

  // read selection; stored reserved bits are always zero
  assign readMux = hitInput  ? inputCfg   :
                   hitGain   ? analogGain :
                   hitVolume ? digVolume  :
                   hitCal    ? calibrate  : 8'h00;

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  // writes pass the writable mask so reserved bits stay zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      inputCfg   <= cocr_pkg::RST_INPUT_CFG;
      analogGain <= cocr_pkg::RST_ANALOG_GN;
      digVolume  <= cocr_pkg::RST_DIG_VOLUME;
      calibrate  <= cocr_pkg::RST_CALIBRATE;
    end else if (doWrite) begin
      if (hitInput) begin
        inputCfg <= regWrData & cocr_pkg::MASK_INPUT_CFG;
      end
      if (hitGain) begin
        analogGain <= regWrData & cocr_pkg::MASK_ANALOG_GN;
      end
      if (hitVolume) begin
        digVolume <= regWrData & cocr_pkg::MASK_DIG_VOLUME;
      end
      if (hitCal) begin
        calibrate <= regWrData & cocr_pkg::MASK_CALIBRATE;
      end
    end
  end

  // answer: ack one cycle after a mapped access, data held until next mapped read
  always_ff @(posedge mclk) begin
    if (reset) begin
      regAck    <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      regAck <= regStrobe && anyHit;
      if (doRead) begin
        regRdData <= readMux;
      end
    end
  end

  // ------------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------------
  logic       decLine;
  logic [1:0] decSource;
  logic       decSrcRes;
  logic       decDc;
  logic [1:0] decImp;
  logic       decImpRes;
  logic       decBoost;
  logic       decAgc;
  logic [5:0] decGain;
  logic       decGainRes;
  logic       decMute;
  logic [8:0] decVolume;
  logic [4:0] decTrim;

  // lies with software: pin functions must match the source chosen
  cocr_decode u_decode (
    .inputCfg          (inputCfg),
    .analogGain        (analogGain),
    .digVolume         (digVolume),
    .calibrate         (calibrate),
    .boostModeSel      (boostModeSel),
    .lineInput         (decLine),
    .sourceSelect      (decSource),
    .sourceAnalog      (),
    .sourceDensityMic  (),
    .sourceReserved    (decSrcRes),
    .dcCoupled         (decDc),
    .impedance         (decImp),
    .impedanceReserved (decImpRes),
    .rangeBoostOn      (decBoost),
    .gainControlOn     (decAgc),
    .gainDb            (decGain),
    .gainReserved      (decGainRes),
    .volumeMuted       (decMute),
    .volumeHalfDb      (decVolume),
    .trimTenthDb       (decTrim)
  );

  // outputs registered one cycle behind the stored bytes
  always_ff @(posedge mclk) begin
    if (reset) begin
      chanOneInputKind         <= 1'b0;
      chanOneSourceSelect      <= 2'h0;
      chanOneSourceReserved    <= 1'b0;
      chanOneCoupling          <= 1'b0;
      chanOneImpedance         <= 2'h0;
      chanOneImpedanceReserved <= 1'b0;
      chanOneRangeBoostOn      <= 1'b0;
      chanOneGainControlOn     <= 1'b0;
      chanOneAnalogGain        <= 6'h00;
      chanOneGainReserved      <= 1'b0;
      chanOneVolumeMuted       <= 1'b0;
      chanOneVolume            <= 9'h000;
      chanOneGainTrim          <= 5'h00;
    end else begin
      chanOneInputKind         <= decLine;
      chanOneSourceSelect      <= decSource;
      chanOneSourceReserved    <= decSrcRes;
      chanOneCoupling          <= decDc;
      chanOneImpedance         <= decImp;
      chanOneImpedanceReserved <= decImpRes;
      chanOneRangeBoostOn      <= decBoost;
      chanOneGainControlOn     <= decAgc;
      chanOneAnalogGain        <= decGain;
      chanOneGainReserved      <= decGainRes;
      chanOneVolumeMuted       <= decMute;
      chanOneVolume            <= decVolume;
      chanOneGainTrim          <= decTrim;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_kind;
    @(posedge mclk) disable iff (reset)
      !$past(reset) |-> chanOneInputKind == $past(inputCfg[7]);
  endproperty
  a_kind: assert property (p_kind)
    else $error("input kind output does not follow bit 7");

  property p_density;
    @(posedge mclk) disable iff (reset)
      ($past(inputCfg[6:5]) == 2'h2) && !$past(reset) |->
        chanOneSourceSelect == 2'h2 && !chanOneCoupling &&
        chanOneImpedance == 2'h0;
  endproperty
  a_density: assert property (p_density)
    else $error("density mic source leaks analog settings");

  property p_coupling;
    @(posedge mclk) disable iff (reset)
      chanOneCoupling |->
        $past(inputCfg[4]) && !$past(inputCfg[6]);
  endproperty
  a_coupling: assert property (p_coupling)
    else $error("dc coupling set without analog source");

  property p_impedance;
    @(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(inputCfg[6]) |->
        chanOneImpedance == $past(inputCfg[3:2]);
  endproperty
  a_impedance: assert property (p_impedance)
    else $error("impedance code wrong for analog source");

  property p_boost_off;
    @(posedge mclk) disable iff (reset)
      !$past(inputCfg[0]) |->
        !chanOneRangeBoostOn && !chanOneGainControlOn;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("enhancer or gain controller on while disabled");

  property p_gain;
    @(posedge mclk) disable iff (reset)
      !$past(reset) |-> chanOneAnalogGain == $past(analogGain[7:2]) &&
        chanOneGainReserved == ($past(analogGain[7:2]) > 6'h2A);
  endproperty
  a_gain: assert property (p_gain)
    else $error("analog gain output mismatches code");

  property p_mute;
    @(posedge mclk) disable iff (reset)
      !$past(reset) |->
        chanOneVolumeMuted == ($past(digVolume) == 8'h00);
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute does not match volume code zero");

  property p_unity;
    @(posedge mclk) disable iff (reset)
      $past(reset) |-> digVolume == 8'hC9 ##1 chanOneVolume == 9'h000;
  endproperty
  a_unity: assert property (p_unity)
    else $error("volume does not start at unity");

  property p_write;
    @(posedge mclk) disable iff (reset)
      regStrobe && regWrite && regPage == 8'h00 && regAddr == 8'h3D |=>
        analogGain == ($past(regWrData) & 8'hFC) ##1
        chanOneAnalogGain == $past(regWrData[7:2], 2);
  endproperty
  a_write: assert property (p_write)
    else $error("write to gain register not stored");

  property p_reset_vals;
    @(posedge mclk) disable iff (reset)
      $past(reset) |-> inputCfg == 8'h00 && analogGain == 8'h00 &&
        calibrate == 8'h80;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset value wrong");

  property p_trim;
    @(posedge mclk) disable iff (reset)
      $past(calibrate[7:4]) == 4'h8 && !$past(reset) |->
        chanOneGainTrim == 5'h00;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim code eight is not zero dB");

  property p_reserved_read;
    @(posedge mclk) disable iff (reset)
      regStrobe && !regWrite && regPage == 8'h00 && regAddr == 8'h3F |=>
        regAck && regRdData[3:0] == 4'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved calibration bits read nonzero");

endmodule

`default_nettype wire

// *** rtl/cocr_pkg.sv ***
// constants for the channel one configuration register bank
// assumes a single clock domain and page/address register access
package cocr_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] PAGE_CONFIG     = 8'h00;
  localparam logic [7:0] ADDR_INPUT_CFG  = 8'h3C;
  localparam logic [7:0] ADDR_ANALOG_GN  = 8'h3D;
  localparam logic [7:0] ADDR_DIG_VOLUME = 8'h3E;
  localparam logic [7:0] ADDR_CALIBRATE  = 8'h3F;

  // ------------------------------------------------------------------
  // reset values and writable bit masks
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_CFG   = 8'h00;
  localparam logic [7:0] RST_ANALOG_GN   = 8'h00;
  localparam logic [7:0] RST_DIG_VOLUME  = 8'hC9;
  localparam logic [7:0] RST_CALIBRATE   = 8'h80;
  localparam logic [7:0] MASK_INPUT_CFG  = 8'hFD;
  localparam logic [7:0] MASK_ANALOG_GN  = 8'hFC;
  localparam logic [7:0] MASK_DIG_VOLUME = 8'hFF;
  localparam logic [7:0] MASK_CALIBRATE  = 8'hF0;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int POS_KIND     = 7;
  localparam int POS_SRC_LO   = 5;
  localparam int POS_COUPLING = 4;
  localparam int POS_IMP_LO   = 2;
  localparam int POS_BOOST    = 0;
  localparam int POS_GAIN_LO  = 2;
  localparam int POS_TRIM_LO  = 4;
  localparam int POS_MODE_SEL = 3;

  // ------------------------------------------------------------------
  // codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SRC_ANALOG_DIFF   = 2'h0;
  localparam logic [1:0] SRC_ANALOG_SINGLE = 2'h1;
  localparam logic [1:0] SRC_DENSITY_MIC   = 2'h2;
  localparam logic [1:0] IMP_RESERVED      = 2'h3;
  localparam logic [5:0] GAIN_MAX_CODE     = 6'h2A;
  localparam logic [7:0] VOLUME_MUTE_CODE  = 8'h00;
  localparam logic [8:0] VOLUME_UNITY_CODE = 9'h0C9;
  localparam logic [4:0] TRIM_ZERO_CODE    = 5'h08;

endpackage

// *** rtl/cocr_decode.sv ***
// decoder turning the four stored bytes into channel controls
// assumes the caller registers every output it drives off chip
`timescale 1ns/1ps
`default_nettype none

module cocr_decode (
  input  wire logic [7:0] inputCfg,
  input  wire logic [7:0] analogGain,
  input  wire logic [7:0] digVolume,
  input  wire logic [7:0] calibrate,
  input  wire logic       boostModeSel,
  output logic            lineInput,
  output logic [1:0]      sourceSelect,
  output logic            sourceAnalog,
  output logic            sourceDensityMic,
  output logic            sourceReserved,
  output logic            dcCoupled,
  output logic [1:0]      impedance,
  output logic            impedanceReserved,
  output logic            rangeBoostOn,
  output logic            gainControlOn,
  output logic [5:0]      gainDb,
  output logic            gainReserved,
  output logic            volumeMuted,
  output logic [8:0]      volumeHalfDb,
  output logic [4:0]      trimTenthDb
);

  // ------------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------------
  wire logic       boostEnable;
  wire logic [5:0] gainCode;
  wire logic [4:0] trimCode;

  assign boostEnable = inputCfg[cocr_pkg::POS_BOOST];
  assign gainCode    = analogGain[cocr_pkg::POS_GAIN_LO +: 6];
  assign trimCode    = {1'b0, calibrate[cocr_pkg::POS_TRIM_LO +: 4]};

  // input kind and source
  assign lineInput        = inputCfg[cocr_pkg::POS_KIND];
  assign sourceSelect     = inputCfg[cocr_pkg::POS_SRC_LO +: 2];
  assign sourceAnalog     = (sourceSelect == cocr_pkg::SRC_ANALOG_DIFF) ||
                            (sourceSelect == cocr_pkg::SRC_ANALOG_SINGLE);
  assign sourceDensityMic = (sourceSelect == cocr_pkg::SRC_DENSITY_MIC);
  assign sourceReserved   = !sourceAnalog && !sourceDensityMic;

  // analog-only front end settings
  assign dcCoupled = sourceAnalog &&
                     inputCfg[cocr_pkg::POS_COUPLING];
  assign impedance = sourceAnalog ?
                     inputCfg[cocr_pkg::POS_IMP_LO +: 2] : 2'h0;
  assign impedanceReserved = (impedance == cocr_pkg::IMP_RESERVED);

  // enhancer or gain controller, picked by the boostModeSel input
  assign rangeBoostOn  = boostEnable && !boostModeSel;
  assign gainControlOn = boostEnable && boostModeSel;

  // analog gain, 1 dB per code
  assign gainDb       = gainCode;
  assign gainReserved = (gainCode > cocr_pkg::GAIN_MAX_CODE);

  // digital volume in half-dB steps relative to unity
  assign volumeMuted  = (digVolume == cocr_pkg::VOLUME_MUTE_CODE);
  assign volumeHalfDb = volumeMuted ? 9'h000 :
                        {1'b0, digVolume} -
                        cocr_pkg::VOLUME_UNITY_CODE;

  // gain trim in tenth-dB steps, signed around code eight
  assign trimTenthDb = trimCode - cocr_pkg::TRIM_ZERO_CODE;

endmodule

`default_nettype wire

// *** bench/test_channel_one_config_regs.sv ***
// self-checking bench for the channel one configuration register bank
// assumes cocr_regs as the only module instantiated here, driven at falling edges
`timescale 1ns/1ps
`default_nettype none

module test_channel_one_config_regs;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic       mclk;
  logic       reset;
  logic       regStrobe;
  logic       regWrite;
  logic [7:0] regPage;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       boostModeSel;
  logic [7:0] regRdData;
  logic       regAck;
  logic       chanOneInputKind;
  logic [1:0] chanOneSourceSelect;
  logic       chanOneSourceReserved;
  logic       chanOneCoupling;
  logic [1:0] chanOneImpedance;
  logic       chanOneImpedanceReserved;
  logic       chanOneRangeBoostOn;
  logic       chanOneGainControlOn;
  logic [5:0] chanOneAnalogGain;
  logic       chanOneGainReserved;
  logic       chanOneVolumeMuted;
  logic [8:0] chanOneVolume;
  logic [4:0] chanOneGainTrim;
  logic       ackSeen;
  logic [7:0] rdSeen;
  int         miscompares;
  int         n_compared;

  cocr_regs cocr_regs_i (
    .mclk                     (mclk),
    .reset                    (reset),
    .regStrobe                (regStrobe),
    .regWrite                 (regWrite),
    .regPage                  (regPage),
    .regAddr                  (regAddr),
    .regWrData                (regWrData),
    .boostModeSel             (boostModeSel),
    .regRdData                (regRdData),
    .regAck                   (regAck),
    .chanOneInputKind         (chanOneInputKind),
    .chanOneSourceSelect      (chanOneSourceSelect),
    .chanOneSourceReserved    (chanOneSourceReserved),
    .chanOneCoupling          (chanOneCoupling),
    .chanOneImpedance         (chanOneImpedance),
    .chanOneImpedanceReserved (chanOneImpedanceReserved),
    .chanOneRangeBoostOn      (chanOneRangeBoostOn),
    .chanOneGainControlOn     (chanOneGainControlOn),
    .chanOneAnalogGain        (chanOneAnalogGain),
    .chanOneGainReserved      (chanOneGainReserved),
    .chanOneVolumeMuted       (chanOneVolumeMuted),
    .chanOneVolume            (chanOneVolume),
    .chanOneGainTrim          (chanOneGainTrim)
  );

  // ------------------------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------------------------
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // compare and count
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one access: strobe for one cycle, capture answer, let outputs settle
  task automatic access(input logic wr, input logic [7:0] pg,
                        input logic [7:0] ad, input logic [7:0] wd);
    regStrobe = 1'b1;
    regWrite  = wr;
    regPage   = pg;
    regAddr   = ad;
    regWrData = wd;
    @(negedge mclk);
    regStrobe = 1'b0;
    ackSeen   = regAck;
    rdSeen    = regRdData;
    @(negedge mclk);
  endtask

  // mapped write, acknowledged
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    access(1'b1, cocr_pkg::PAGE_CONFIG, ad, wd);
    check({8'h00, ackSeen}, 9'h001);
  endtask

  // mapped read compared with expected byte
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    access(1'b0, cocr_pkg::PAGE_CONFIG, ad, 8'h00);
    check({8'h00, ackSeen}, 9'h001);
    check({1'b0, rdSeen}, {1'b0, exp});
  endtask

  // verdict
  task automatic finish_test;
    $display("compares %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // reset values of registers and decoded controls
  task automatic test_reset;
    rd(cocr_pkg::ADDR_INPUT_CFG, 8'h00);
    rd(cocr_pkg::ADDR_ANALOG_GN, 8'h00);
    rd(cocr_pkg::ADDR_DIG_VOLUME, 8'hC9);
    rd(cocr_pkg::ADDR_CALIBRATE, 8'h80);
    check({8'h00, chanOneInputKind}, 9'h000);
    check({8'h00, chanOneVolumeMuted}, 9'h000);
    check(chanOneVolume, 9'h000);
    check({4'h0, chanOneGainTrim}, 9'h000);
    check({3'h0, chanOneAnalogGain}, 9'h000);
    $display("test_reset done");
  endtask

  // every source code with coupling, impedance and reserved bit set
  task automatic test_source;
    logic [7:0] v;
    logic       an;
    for (int i = 0; i < 4; i++) begin
      v  = {i[0], i[1:0], 5'h1E};
      an = (i < 2);
      // pin functions sit outside this block, assumed set to match
      wr(cocr_pkg::ADDR_INPUT_CFG, v);
      rd(cocr_pkg::ADDR_INPUT_CFG, v & 8'hFD);
      check({8'h00, chanOneInputKind}, {8'h00, i[0]});
      check({7'h00, chanOneSourceSelect}, {7'h00, i[1:0]});
      check({8'h00, chanOneSourceReserved}, {8'h00, i == 3});
      check({8'h00, chanOneCoupling}, {8'h00, an});
      check({7'h00, chanOneImpedance}, an ? 9'h003 : 9'h000);
      check({8'h00, chanOneImpedanceReserved}, {8'h00, an});
    end
    wr(cocr_pkg::ADDR_INPUT_CFG, 8'h28);
    check({7'h00, chanOneImpedance}, 9'h002);
    check({8'h00, chanOneImpedanceReserved}, 9'h000);
    check({8'h00, chanOneCoupling}, 9'h000);
    wr(cocr_pkg::ADDR_INPUT_CFG, 8'h04);
    check({7'h00, chanOneImpedance}, 9'h001);
    check({8'h00, chanOneImpedanceReserved}, 9'h000);
    $display("test_source done");
  endtask

  // enable bit and mode select pick enhancer or gain controller
  task automatic test_boost;
    for (int m = 0; m < 2; m++) begin
      boostModeSel = m[0];
      wr(cocr_pkg::ADDR_INPUT_CFG, 8'h01);
      check({8'h00, chanOneRangeBoostOn}, {8'h00, ~m[0]});
      check({8'h00, chanOneGainControlOn}, {8'h00, m[0]});
      wr(cocr_pkg::ADDR_INPUT_CFG, 8'h00);
      check({7'h00, chanOneRangeBoostOn, chanOneGainControlOn}, 9'h000);
    end
    $display("test_boost done");
  endtask

  // gain codes at both ends of the legal range and beyond
  task automatic test_gain;
    logic [5:0] codes [4];
    codes = '{6'h00, 6'h2A, 6'h2B, 6'h3F};
    foreach (codes[k]) begin
      wr(cocr_pkg::ADDR_ANALOG_GN, {codes[k], 2'h3});
      rd(cocr_pkg::ADDR_ANALOG_GN, {codes[k], 2'h0});
      check({3'h0, chanOneAnalogGain}, {3'h0, codes[k]});
      check({8'h00, chanOneGainReserved}, {8'h00, codes[k] > 6'h2A});
    end
    $display("test_gain done");
  endtask

  // volume: mute, lowest, unity, highest
  task automatic test_volume;
    logic [7:0] codes [4];
    codes = '{8'h00, 8'h01, 8'hC9, 8'hFF};
    foreach (codes[k]) begin
      wr(cocr_pkg::ADDR_DIG_VOLUME, codes[k]);
      rd(cocr_pkg::ADDR_DIG_VOLUME, codes[k]);
      check({8'h00, chanOneVolumeMuted}, {8'h00, codes[k] == 0});
      check(chanOneVolume, codes[k] == 0 ? 9'h000 :
            {1'b0, codes[k]} - 9'h0C9);
    end
    $display("test_volume done");
  endtask

  // calibration nibble extremes and reserved low nibble
  task automatic test_trim;
    logic [3:0] codes [3];
    codes = '{4'h0, 4'h8, 4'hF};
    foreach (codes[k]) begin
      wr(cocr_pkg::ADDR_CALIBRATE, {codes[k], 4'hF});
      rd(cocr_pkg::ADDR_CALIBRATE, {codes[k], 4'h0});
      check({4'h0, chanOneGainTrim}, {4'h0, {1'b0, codes[k]} - 5'h08});
    end
    $display("test_trim done");
  endtask

  // unmapped page and neighbour addresses: no ack, no change
  task automatic test_unmapped;
    rd(cocr_pkg::ADDR_DIG_VOLUME, 8'hFF);
    access(1'b1, 8'h01, cocr_pkg::ADDR_DIG_VOLUME, 8'h12);
    check({8'h00, ackSeen}, 9'h000);
    access(1'b1, cocr_pkg::PAGE_CONFIG, 8'h3B, 8'h34);
    check({8'h00, ackSeen}, 9'h000);
    access(1'b0, cocr_pkg::PAGE_CONFIG, 8'h40, 8'h00);
    check({8'h00, ackSeen}, 9'h000);
    check({1'b0, rdSeen}, 9'h0FF);
    rd(cocr_pkg::ADDR_DIG_VOLUME, 8'hFF);
    check(chanOneVolume, 9'h036);
    $display("test_unmapped done");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    miscompares  = 0;
    n_compared   = 0;
    reset        = 1'b1;
    regStrobe    = 1'b0;
    regWrite     = 1'b0;
    regPage      = 8'h00;
    regAddr      = 8'h00;
    regWrData    = 8'h00;
    boostModeSel = 1'b0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    test_reset();
    test_source();
    test_boost();
    test_gain();
    test_volume();
    test_trim();
    test_unmapped();
    finish_test();
  end

endmodule

`default_nettype wire
